// ### core/irdec_params.svh
`ifndef IRDEC_PARAMS_SVH
`define IRDEC_PARAMS_SVH

// Clock rate and frame layout
`define IRDEC_CLK_HZ 10000000
`define IRDEC_FRAME_BITS 12
`define IRDEC_SR_BITS 10
`define IRDEC_MC_BITS 3
`define IRDEC_KEY_BITS 6
`define IRDEC_GRP_BITS 3

// Group codes, first group bit received is the MSB
`define IRDEC_GRP_HOLD 3'h4
`define IRDEC_GRP_PULSE 3'h2
`define IRDEC_GRP_EXT 3'h1

// Output masks per package variant, packed as {hold, pulse, flip}
`define IRDEC_MASK_FULL {6'h3F, 10'h3FF, 2'h3}
`define IRDEC_MASK_SMALL {6'h1F, 10'h01F, 2'h0}
`define IRDEC_MASK_SMALL_FLIP {6'h1F, 10'h007, 2'h3}

// Times in their own units
`define IRDEC_HOLD_MS 160
`define IRDEC_PULSE_MS 107
`define IRDEC_ONE_MIN_US 800
`define IRDEC_GLITCH_US 100
`define IRDEC_GAP_US 4000

// Longest times round down, least times round up
`define IRDEC_HOLD_CYC (`IRDEC_HOLD_MS * (`IRDEC_CLK_HZ / 1000))
`define IRDEC_PULSE_CYC (`IRDEC_PULSE_MS * (`IRDEC_CLK_HZ / 1000))
`define IRDEC_ONE_MIN_CYC \
	((`IRDEC_ONE_MIN_US * (`IRDEC_CLK_HZ / 1000) + 999) / 1000)
`define IRDEC_GLITCH_CYC \
	((`IRDEC_GLITCH_US * (`IRDEC_CLK_HZ / 1000) + 999) / 1000)
`define IRDEC_GAP_CYC \
	((`IRDEC_GAP_US * (`IRDEC_CLK_HZ / 1000) + 999) / 1000)

`endif

// ### core/irdec_pkg.sv
`include "irdec_params.svh"

package irdec_pkg;

	typedef enum logic [1:0] {
		VAR_FULL,
		VAR_SMALL,
		VAR_SMALL_FLIP
	} variant_t;

	typedef enum logic {
		ST_WAIT_FIRST,
		ST_WAIT_SECOND
	} pair_state_t;

	typedef struct packed {
		logic [5:0] hold;
		logic [9:0] pulse;
		logic [1:0] flip;
	} key_out_t;

	typedef struct packed {
		logic [`IRDEC_GRP_BITS-1:0] group;
		logic [`IRDEC_KEY_BITS-1:0] key;
	} key_code_t;

endpackage

// ### core/ir_bit_rx.sv
`include "irdec_params.svh"

// Turns the cleaned receiver level into bits and a frame end.
// A bit is one high mark; a long mark is a one, a short mark a zero.
module ir_bit_rx #(
	parameter int unsigned ONE_MIN_CYC = `IRDEC_ONE_MIN_CYC,
	parameter int unsigned GLITCH_CYC = `IRDEC_GLITCH_CYC,
	parameter int unsigned GAP_CYC = `IRDEC_GAP_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Synchronised, polarity-corrected receiver level
	input wire logic level,
	// Decoded bit stream
	output logic bit_valid,
	output logic bit_value,
	output logic frame_end
);

	localparam int CW = $clog2(GAP_CYC + 1);

	logic prev_r;
	logic seen_r;
	logic [CW-1:0] high_cnt_r;
	logic [CW-1:0] low_cnt_r;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= level;
		end
	end

	// Counters saturate so a stuck input cannot wrap into a valid bit
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			high_cnt_r <= '0;
			low_cnt_r <= '0;
		end else if (level) begin
			low_cnt_r <= '0;
			if (high_cnt_r != CW'(GAP_CYC)) begin
				high_cnt_r <= high_cnt_r + 1'b1;
			end
		end else begin
			high_cnt_r <= '0;
			if (low_cnt_r != CW'(GAP_CYC)) begin
				low_cnt_r <= low_cnt_r + 1'b1;
			end
		end
	end

	// Marks shorter than the glitch time are dropped as noise
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bit_valid <= 1'b0;
			bit_value <= 1'b0;
			frame_end <= 1'b0;
			seen_r <= 1'b0;
		end else begin
			bit_valid <= 1'b0;
			frame_end <= 1'b0;
			if (prev_r && !level && high_cnt_r >= CW'(GLITCH_CYC)) begin
				bit_valid <= 1'b1;
				bit_value <= (high_cnt_r >= CW'(ONE_MIN_CYC));
				seen_r <= 1'b1;
			end else if (seen_r && !level &&
					low_cnt_r == CW'(GAP_CYC - 1)) begin
				frame_end <= 1'b1;
				seen_r <= 1'b0;
			end
		end
	end

endmodule

// ### core/ir_remote_key_decoder.sv
`include "irdec_params.svh"

// Contract
// - Twelve-bit frames pass a ten-bit shift register
// - Leading three bits compared with match pins
// - Second frame compared bitwise with first frame
// - Equal frame pair gives the latch pulse
// - Single-shot keys give one pulse each
// - Continuous keys drive hold outputs high
// - Hold stays high 160 ms after pair
// - Toggle keys flip their output once per new key event
// - Three group bits select output bank
// - Full variant decodes all eighteen keys
// - Small variant: five hold, five pulse
// - Small toggle variant: five, three, two
// - Pulse outputs last 107 ms
// - Build option inverts the serial input
// - Frames with wrong match code are ignored
module ir_remote_key_decoder
	import irdec_pkg::*;
#(
	parameter variant_t VARIANT = VAR_FULL,
	parameter bit INVERT_INPUT = 1'b0,
	parameter bit FLIP_DEPENDENT = 1'b0,
	parameter int unsigned HOLD_CYC = `IRDEC_HOLD_CYC,
	parameter int unsigned PULSE_CYC = `IRDEC_PULSE_CYC,
	parameter int unsigned ONE_MIN_CYC = `IRDEC_ONE_MIN_CYC,
	parameter int unsigned GLITCH_CYC = `IRDEC_GLITCH_CYC,
	parameter int unsigned GAP_CYC = `IRDEC_GAP_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Receiver pins
	input wire logic ir_serial_input,
	input wire logic [`IRDEC_MC_BITS-1:0] match_code_pin,
	// Decoded key outputs
	output key_out_t key_out
);

	localparam int HW = $clog2(HOLD_CYC + 1);
	localparam int PW = $clog2(PULSE_CYC + 1);
	localparam int IW = $clog2(`IRDEC_FRAME_BITS + 2);
	localparam int SRW = `IRDEC_SR_BITS;
	localparam int MCW = `IRDEC_MC_BITS;
	localparam int KW = `IRDEC_KEY_BITS;
	localparam key_out_t VMASK = (VARIANT == VAR_FULL) ? `IRDEC_MASK_FULL :
		(VARIANT == VAR_SMALL) ? `IRDEC_MASK_SMALL :
		`IRDEC_MASK_SMALL_FLIP;

	logic in_meta_r;
	logic in_sync_r;
	logic [MCW-1:0] mc_meta_r;
	logic [MCW-1:0] mc_sync_r;
	logic rx_level;
	logic bit_valid;
	logic bit_value;
	logic frame_end;
	logic [SRW-1:0] sr_r;
	logic [SRW-1:0] first_r;
	logic [IW-1:0] idx_r;
	logic mc_ok_r;
	logic frame_ok;
	pair_state_t state_r;
	logic latch_r;
	key_code_t code_r;
	logic [KW-1:0] key_rev;
	key_out_t dec_raw;
	key_out_t dec;
	logic key_active_r;
	key_code_t last_r;
	logic fire;
	logic [HW-1:0] rel_cnt_r;
	logic [PW-1:0] pulse_cnt_r;
	logic [5:0] hold_r;
	logic [9:0] pulse_r;
	logic [1:0] flip_r;
	logic [1:0] flip_nxt;

	// Reset to the idle level, else inverted input sees a false mark
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			in_meta_r <= INVERT_INPUT;
			in_sync_r <= INVERT_INPUT;
			mc_meta_r <= '0;
			mc_sync_r <= '0;
		end else begin
			in_meta_r <= ir_serial_input;
			in_sync_r <= in_meta_r;
			mc_meta_r <= match_code_pin;
			mc_sync_r <= mc_meta_r;
		end
	end

	assign rx_level = in_sync_r ^ INVERT_INPUT;

	ir_bit_rx #(
		.ONE_MIN_CYC(ONE_MIN_CYC),
		.GLITCH_CYC(GLITCH_CYC),
		.GAP_CYC(GAP_CYC)
	) u_bit_rx (
		.sys_clk(sys_clk),
		.rst(rst),
		.level(rx_level),
		.bit_valid(bit_valid),
		.bit_value(bit_value),
		.frame_end(frame_end)
	);

	// Only the last ten bits of the stream are kept
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sr_r <= '0;
		end else if (bit_valid) begin
			sr_r <= {sr_r[SRW-2:0], bit_value};
		end
	end

	// Overlong frames saturate the count and fail the length check
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			idx_r <= '0;
		end else if (frame_end) begin
			idx_r <= '0;
		end else if (bit_valid && idx_r != IW'(`IRDEC_FRAME_BITS + 1)) begin
			idx_r <= idx_r + 1'b1;
		end
	end

	// Match code is checked bit by bit as it passes, MSB first
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mc_ok_r <= 1'b1;
		end else if (frame_end) begin
			mc_ok_r <= 1'b1;
		end else if (bit_valid && idx_r < IW'(MCW) &&
				bit_value != mc_sync_r[MCW-1-idx_r]) begin
			mc_ok_r <= 1'b0;
		end
	end

	assign frame_ok = frame_end && mc_ok_r &&
		idx_r == IW'(`IRDEC_FRAME_BITS);

	// Frame pairing; any failure drops back to waiting for a first frame
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_WAIT_FIRST;
			first_r <= '0;
			latch_r <= 1'b0;
			code_r <= '0;
		end else begin
			latch_r <= 1'b0;
			if (frame_end && !frame_ok) begin
				state_r <= ST_WAIT_FIRST;
			end else if (frame_end) begin
				unique case (state_r)
					ST_WAIT_FIRST: begin
						first_r <= sr_r;
						state_r <= ST_WAIT_SECOND;
					end
					ST_WAIT_SECOND: begin
						state_r <= ST_WAIT_FIRST;
						if (sr_r == first_r) begin
							latch_r <= 1'b1;
							code_r <= {sr_r[KW+2:KW], key_rev};
						end
					end
				endcase
			end
		end
	end

	// First key bit received lands in key[0]
	genvar gi;
	generate
		for (gi = 0; gi < KW; gi++) begin : g_key
			assign key_rev[gi] = sr_r[KW-1-gi];
		end
	endgenerate

	always_comb begin
		dec_raw = '0;
		case (code_r.group)
			`IRDEC_GRP_HOLD: dec_raw.hold = code_r.key;
			`IRDEC_GRP_PULSE: dec_raw.pulse[5:0] = code_r.key;
			`IRDEC_GRP_EXT: begin
				dec_raw.pulse[9:6] = code_r.key[3:0];
				dec_raw.flip = code_r.key[5:4];
			end
			default: dec_raw = '0;
		endcase
	end

	assign dec = dec_raw & VMASK;

	// A held key repeats frames; only a new code, or any code once the hold time has run out, counts as an event
	assign fire = latch_r && (!key_active_r || code_r != last_r);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			key_active_r <= 1'b0;
			last_r <= '0;
			rel_cnt_r <= '0;
		end else if (latch_r) begin
			key_active_r <= 1'b1;
			last_r <= code_r;
			rel_cnt_r <= HW'(HOLD_CYC);
		end else if (rel_cnt_r != '0) begin
			rel_cnt_r <= rel_cnt_r - 1'b1;
			if (rel_cnt_r == HW'(1)) begin
				key_active_r <= 1'b0;
			end
		end
	end

	// Another key replaces the hold bank at once
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hold_r <= '0;
		end else if (latch_r) begin
			hold_r <= dec.hold;
		end else if (rel_cnt_r == HW'(1)) begin
			hold_r <= '0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pulse_r <= '0;
			pulse_cnt_r <= '0;
		end else if (fire && dec.pulse != '0) begin
			pulse_r <= dec.pulse;
			pulse_cnt_r <= PW'(PULSE_CYC);
		end else if (pulse_cnt_r != '0) begin
			pulse_cnt_r <= pulse_cnt_r - 1'b1;
			if (pulse_cnt_r == PW'(1)) begin
				pulse_r <= '0;
			end
		end
	end

	// Dependent mode: a toggle key clears any toggle output that it does not select
	always_comb begin
		flip_nxt = flip_r ^ dec.flip;
		if (FLIP_DEPENDENT && dec.flip != '0) begin
			flip_nxt = (flip_r ^ dec.flip) & dec.flip;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flip_r <= '0;
		end else if (fire) begin
			flip_r <= flip_nxt;
		end
	end

	assign key_out = '{hold: hold_r, pulse: pulse_r, flip: flip_r};

	property p_frame_len;
		@(posedge sys_clk) disable iff (rst)
		latch_r |-> $past(idx_r) == IW'(`IRDEC_FRAME_BITS);
	endproperty
	a_frame_len: assert property (p_frame_len)
		else $error("latch without a twelve-bit frame");

	property p_mc_reject;
		@(posedge sys_clk) disable iff (rst)
		(frame_end && !mc_ok_r) |=> !latch_r && state_r == ST_WAIT_FIRST;
	endproperty
	a_mc_reject: assert property (p_mc_reject)
		else $error("frame with bad match code was used");

	property p_pair_equal;
		@(posedge sys_clk) disable iff (rst)
		latch_r |-> $past(sr_r) == $past(first_r) &&
			$past(state_r) == ST_WAIT_SECOND;
	endproperty
	a_pair_equal: assert property (p_pair_equal)
		else $error("latch without two equal frames");

	property p_fail_quiet;
		@(posedge sys_clk) disable iff (rst)
		(frame_end && !frame_ok) |=> !latch_r ##1 !fire;
	endproperty
	a_fail_quiet: assert property (p_fail_quiet)
		else $error("failed frame produced a key event");

	property p_hold_set;
		@(posedge sys_clk) disable iff (rst)
		latch_r |=> hold_r == $past(dec.hold) &&
			rel_cnt_r == HW'(HOLD_CYC);
	endproperty
	a_hold_set: assert property (p_hold_set)
		else $error("hold outputs did not follow the key");

	property p_hold_release;
		@(posedge sys_clk) disable iff (rst)
		(rel_cnt_r == HW'(1) && !latch_r) |=> hold_r == '0 && !key_active_r;
	endproperty
	a_hold_release: assert property (p_hold_release)
		else $error("hold outputs did not release on time");

	property p_pulse_start;
		@(posedge sys_clk) disable iff (rst)
		(fire && dec.pulse != '0) |=> pulse_r == $past(dec.pulse) &&
			pulse_cnt_r == PW'(PULSE_CYC);
	endproperty
	a_pulse_start: assert property (p_pulse_start)
		else $error("pulse output did not start");

	property p_pulse_end;
		@(posedge sys_clk) disable iff (rst)
		(pulse_cnt_r == PW'(1) && !fire) |=> pulse_r == '0;
	endproperty
	a_pulse_end: assert property (p_pulse_end)
		else $error("pulse output did not end on time");

	property p_flip;
		@(posedge sys_clk) disable iff (rst)
		!FLIP_DEPENDENT |=> flip_r ==
			($past(flip_r) ^ ($past(fire) ? $past(dec.flip) : 2'b00));
	endproperty
	a_flip: assert property (p_flip)
		else $error("toggle outputs changed wrongly");

	property p_variant;
		@(posedge sys_clk) disable iff (rst)
		(key_out & ~VMASK) == '0;
	endproperty
	a_variant: assert property (p_variant)
		else $error("output outside the variant was driven");

	c_latch: cover property (@(posedge sys_clk) disable iff (rst) latch_r);
	c_flip: cover property (@(posedge sys_clk) disable iff (rst)
		$rose(flip_r[0]));
	c_release: cover property (@(posedge sys_clk) disable iff (rst)
		$fell(hold_r[0]));
	c_reject: cover property (@(posedge sys_clk) disable iff (rst)
		frame_end && !mc_ok_r);

endmodule

// ### verification/ir_tx_model.sv
// Behavioural remote transmitter seen through a demodulating receiver.
// Mark-length coding: a long mark is a one, a short mark a zero.
module ir_tx_model #(
	parameter bit INV = 1'b0,
	parameter int MARK0 = 4,
	parameter int MARK1 = 12,
	parameter int SPACE = 4,
	parameter int GAP = 48
) (
	// Clock
	input wire logic sys_clk,
	// Demodulated receiver level
	output logic ir_level
);
	timeunit 1ns;
	timeprecision 1ns;

	// Receiver output idles at the space level between frames
	initial ir_level = INV;

	// Match code, group bits, then key bits with the first key bit leading
	function automatic logic [11:0] frm(input logic [2:0] mc,
		input logic [2:0] g, input int n);
		return {mc, g, 6'h20 >> (n - 1)};
	endfunction

	task automatic send_frame(input logic [11:0] f);
		for (int i = 11; i >= 0; i--) begin
			@(posedge sys_clk);
			#5 ir_level = ~INV;
			repeat (f[i] ? MARK1 : MARK0) @(posedge sys_clk);
			#5 ir_level = INV;
			repeat (SPACE - 1) @(posedge sys_clk);
		end
	endtask

	// Same frame twice, separated by a gap long enough to end a frame
	task automatic send_pair(input logic [2:0] mc, input logic [2:0] g,
		input int n);
		send_frame(frm(mc, g, n));
		repeat (GAP) @(posedge sys_clk);
		send_frame(frm(mc, g, n));
	endtask
endmodule

// ### verification/ir_remote_key_decoder_test.sv
`include "irdec_params.svh"

`define CHK(got, exp) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) begin \
			errors++; \
			$display("Error at %0t: got %h expected %h", $time, got, exp); \
		end \
	end

module ir_remote_key_decoder_test
	import irdec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// Short counts keep the run small; every expectation follows them
	localparam int HOLD = 200;
	localparam int PULSE = 120;
	localparam logic [2:0] MC = 3'h5;
	localparam logic [2:0] MC_S = 3'h2;
	localparam int ONE_MIN = 8;
	localparam int GLITCH = 2;
	localparam int GAP = 40;

	logic sys_clk;
	logic rst;
	logic ir_full;
	logic ir_small;
	logic [2:0] mc_full;
	logic [2:0] mc_small;
	key_out_t out_full;
	key_out_t out_small;
	logic [1:0] flip_st;
	int errors;
	int cmp_count;

	always #50 sys_clk = ~sys_clk;

	ir_remote_key_decoder #(
		.HOLD_CYC(HOLD), .PULSE_CYC(PULSE), .ONE_MIN_CYC(ONE_MIN),
		.GLITCH_CYC(GLITCH), .GAP_CYC(GAP)
	) u_ir_remote_key_decoder (
		.sys_clk(sys_clk), .rst(rst), .ir_serial_input(ir_full),
		.match_code_pin(mc_full), .key_out(out_full)
	);

	// Small build also runs the dependent toggle mode
	ir_remote_key_decoder #(
		.VARIANT(VAR_SMALL_FLIP), .INVERT_INPUT(1'b1),
		.FLIP_DEPENDENT(1'b1),
		.HOLD_CYC(HOLD), .PULSE_CYC(PULSE), .ONE_MIN_CYC(ONE_MIN),
		.GLITCH_CYC(GLITCH), .GAP_CYC(GAP)
	) u_ir_remote_key_decoder_small (
		.sys_clk(sys_clk), .rst(rst), .ir_serial_input(ir_small),
		.match_code_pin(mc_small), .key_out(out_small)
	);

	ir_tx_model u_ir_tx_model (.sys_clk(sys_clk), .ir_level(ir_full));
	ir_tx_model #(.INV(1'b1)) u_ir_tx_model_inv (
		.sys_clk(sys_clk), .ir_level(ir_small)
	);

	function automatic key_out_t cur(input bit sel);
		return sel ? out_small : out_full;
	endfunction

	task automatic pair(input bit sel, input logic [2:0] g, input int n);
		if (sel) begin
			u_ir_tx_model_inv.send_pair(MC_S, g, n);
		end else begin
			u_ir_tx_model.send_pair(MC, g, n);
		end
	endtask

	// Bounded wait, so a missing update is reported instead of hanging
	task automatic expect_on(input bit sel, input key_out_t e);
		key_out_t got;
		got = cur(sel);
		for (int i = 0; i < 80 && got !== e; i++) begin
			@(posedge sys_clk);
			#5 got = cur(sel);
		end
		`CHK(got, e);
	endtask

	task automatic settle(input bit sel, input key_out_t e);
		repeat (80) @(posedge sys_clk);
		#5;
		`CHK(cur(sel), e);
	endtask

	task automatic run_key(input logic [2:0] g, input int n,
		input logic [5:0] h, input logic [9:0] p, input int dur);
		pair(0, g, n);
		expect_on(0, {h, p, flip_st});
		repeat (dur - 15) @(posedge sys_clk);
		#5;
		`CHK(out_full, key_out_t'({h, p, flip_st}));
		repeat (25) @(posedge sys_clk);
		#5;
		`CHK(out_full, key_out_t'({16'h0000, flip_st}));
	endtask

	// Waits past the hold time so the repeat counts as a new key event
	task automatic t_flip();
		pair(0, `IRDEC_GRP_EXT, 5);
		flip_st = 2'b01;
		expect_on(0, {16'h0000, flip_st});
		repeat (HOLD + 50) @(posedge sys_clk);
		pair(0, `IRDEC_GRP_EXT, 5);
		flip_st = 2'b00;
		expect_on(0, {16'h0000, flip_st});
		repeat (HOLD + 50) @(posedge sys_clk);
		pair(0, `IRDEC_GRP_EXT, 6);
		flip_st = 2'b10;
		expect_on(0, {16'h0000, flip_st});
	endtask

	// Only the first match bit is wrong, so the pair compare cannot catch it.
	// Then the pins move: a once-good code is refused, a new one taken.
	task automatic t_bad_mc();
		u_ir_tx_model.send_pair(MC ^ 3'h4, `IRDEC_GRP_HOLD, 1);
		settle(0, {16'h0000, flip_st});
		mc_full = MC ^ 3'h1;
		u_ir_tx_model.send_pair(MC, `IRDEC_GRP_HOLD, 1);
		settle(0, {16'h0000, flip_st});
		mc_full = MC ^ 3'h4;
		u_ir_tx_model.send_pair(MC ^ 3'h4, `IRDEC_GRP_PULSE, 4);
		expect_on(0, {6'h00, 10'h008, flip_st});
		repeat (PULSE + 20) @(posedge sys_clk);
		#5 mc_full = MC;
	endtask

	task automatic t_differ();
		u_ir_tx_model.send_frame(u_ir_tx_model.frm(MC, `IRDEC_GRP_HOLD, 1));
		repeat (48) @(posedge sys_clk);
		u_ir_tx_model.send_frame(u_ir_tx_model.frm(MC, `IRDEC_GRP_HOLD, 2));
		settle(0, {16'h0000, flip_st});
		pair(0, `IRDEC_GRP_PULSE, 2);
		expect_on(0, {6'h00, 10'h002, flip_st});
		repeat (PULSE + 20) @(posedge sys_clk);
	endtask

	// Dependent mode: the second toggle key clears the first
	task automatic t_small();
		pair(1, `IRDEC_GRP_EXT, 4);
		settle(1, 18'h0_0000);
		pair(1, `IRDEC_GRP_HOLD, 6);
		settle(1, 18'h0_0000);
		pair(1, `IRDEC_GRP_PULSE, 3);
		expect_on(1, {6'h00, 10'h004, 2'b00});
		pair(1, `IRDEC_GRP_EXT, 6);
		expect_on(1, {16'h0000, 2'b10});
		pair(1, `IRDEC_GRP_EXT, 5);
		expect_on(1, {16'h0000, 2'b01});
	endtask

	task automatic end_sim();
		$display("Counts: errors %0d, compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		errors = 0;
		cmp_count = 0;
		flip_st = 2'b00;
		mc_full = MC;
		mc_small = MC_S;
		repeat (16) @(posedge sys_clk);
		#5 rst = 1'b0;
		repeat (4) @(posedge sys_clk);
		run_key(`IRDEC_GRP_HOLD, 1, 6'h01, 10'h000, HOLD);
		run_key(`IRDEC_GRP_HOLD, 6, 6'h20, 10'h000, HOLD);
		run_key(`IRDEC_GRP_PULSE, 1, 6'h00, 10'h001, PULSE);
		run_key(`IRDEC_GRP_PULSE, 6, 6'h00, 10'h020, PULSE);
		run_key(`IRDEC_GRP_EXT, 1, 6'h00, 10'h040, PULSE);
		run_key(`IRDEC_GRP_EXT, 4, 6'h00, 10'h200, PULSE);
		t_flip();
		t_bad_mc();
		t_differ();
		t_small();
		end_sim();
	end

	// About five times the expected length of the run
	initial begin
		repeat (40000) @(posedge sys_clk);
		errors++;
		end_sim();
	end
endmodule
